// >>> charger_opt_pkg.sv
// constants for the charger option high-byte control block
package charger_opt_pkg;

	// ==========================================================
	// register addresses
	localparam logic [7:0] ADDR_OPT0_LOW  = 8'h00;
	localparam logic [7:0] ADDR_OPT0_HIGH = 8'h01;
	localparam logic [7:0] ADDR_CUR_LOW   = 8'h02;
	localparam logic [7:0] ADDR_CUR_HIGH  = 8'h03;
	localparam logic [7:0] ADDR_VOLT_LOW  = 8'h04;
	localparam logic [7:0] ADDR_VOLT_HIGH = 8'h05;
	localparam logic [7:0] ADDR_OPT1_LOW  = 8'h30;
	localparam logic [7:0] ADDR_OPT1_HIGH = 8'h31;

	// ==========================================================
	// field positions, high byte of option register 0
	localparam int BIT_LOW_POWER_ENABLE   = 7;
	localparam int BIT_WD_SEL_HI          = 6;
	localparam int BIT_WD_SEL_LO          = 5;
	localparam int BIT_INPUT_LIMIT_AUTO   = 4;
	localparam int BIT_RB_FLAGS_ADAPTER   = 3;
	localparam int BIT_OUT_OF_AUDIO       = 2;
	// low byte of option register 0
	localparam int BIT_INPUT_REG_ENABLE   = 1;
	// high byte of option register 1
	localparam int BIT_CMP_ENABLE_A       = 6;
	localparam int BIT_CMP_ENABLE_B       = 5;

	// ==========================================================
	// reset and suspend values
	localparam logic [7:0]  OPT0_HIGH_RESET = 8'hE2;
	localparam logic [7:0]  OPT0_LOW_RESET  = 8'h0E;
	localparam logic [7:0]  OPT1_HIGH_RESET = 8'h00;
	localparam logic [15:0] CUR_RESET       = 16'h0000;
	localparam logic [15:0] VOLT_RESET      = 16'h0000;
	localparam logic [15:0] CUR_SUSPEND     = 16'h0000;

	// ==========================================================
	// watchdog selection codes
	localparam logic [1:0] WD_OFF   = 2'h0;
	localparam logic [1:0] WD_SHORT = 2'h1;
	localparam logic [1:0] WD_MID   = 2'h2;
	localparam logic [1:0] WD_LONG  = 2'h3;

	// ==========================================================
	// timing
	localparam longint CLK_HZ        = 10_000_000;
	localparam longint WD_SHORT_S    = 5;
	localparam longint WD_MID_S      = 88;
	localparam longint WD_LONG_S     = 175;
	localparam longint BURST_MIN_HZ  = 25_000;
	localparam longint WD_SHORT_CYC  = WD_SHORT_S * CLK_HZ;
	localparam longint WD_MID_CYC    = WD_MID_S * CLK_HZ;
	localparam longint WD_LONG_CYC   = WD_LONG_S * CLK_HZ;
	localparam logic [8:0] BURST_GAP_CYC = 9'(CLK_HZ / BURST_MIN_HZ);
	localparam logic [8:0] BURST_GAP_ONE = 9'h001;

endpackage : charger_opt_pkg

// >>> interval_timer_if.sv
// carrier between the control block and its interval timers
`timescale 1ns/1ns
`default_nettype none
interface interval_timer_if;
	logic [1:0] sel;
	logic       restart;
	logic       elapsed;

	modport owner (output sel, output restart, input elapsed);
	modport timer (input sel, input restart, output elapsed);
endinterface : interval_timer_if
`default_nettype wire

// >>> interval_timer.sv
// selectable interval timer: flags once the chosen time has passed since restart
`timescale 1ns/1ns
`default_nettype none
module interval_timer
	import charger_opt_pkg::*;
#(
	parameter logic [31:0] SHORT_CYC = 32'(WD_SHORT_CYC),
	parameter logic [31:0] MID_CYC   = 32'(WD_MID_CYC),
	parameter logic [31:0] LONG_CYC  = 32'(WD_LONG_CYC)
)(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	interval_timer_if.timer tmr
);

	typedef struct packed {
		logic [31:0] count;
		logic        elapsed;
	} timer_state_t;

	timer_state_t st;
	timer_state_t next_st;

	function automatic logic [31:0] limitFor(input logic [1:0] sel);
		unique case (sel)
			WD_SHORT: limitFor = SHORT_CYC;
			WD_MID:   limitFor = MID_CYC;
			WD_LONG:  limitFor = LONG_CYC;
			WD_OFF:   limitFor = 32'h0000_0000;
		endcase
	endfunction

	// ==========================================================
	// counting
	always_comb
	begin
		next_st = st;
		if (tmr.restart || tmr.sel == WD_OFF)
		begin
			next_st.count   = 32'h0000_0000;
			next_st.elapsed = 1'b0;
		end
		else if (!st.elapsed)
		begin
			if (st.count >= limitFor(tmr.sel) - 32'h0000_0001)
				next_st.elapsed = 1'b1;
			else
				next_st.count = st.count + 32'h0000_0001;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign tmr.elapsed = st.elapsed;

endmodule : interval_timer
`default_nettype wire

// >>> charger_option_high_byte_ctrl.sv
// control logic behind the high byte of charger option register 0
`timescale 1ns/1ns
`default_nettype none
module charger_option_high_byte_ctrl
	import charger_opt_pkg::*;
#(
	parameter logic [31:0] SHORT_CYC = 32'(WD_SHORT_CYC),
	parameter logic [31:0] MID_CYC   = 32'(WD_MID_CYC),
	parameter logic [31:0] LONG_CYC  = 32'(WD_LONG_CYC)
)(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [7:0]  regRdData,
	input  wire logic        cellCountBatteryPresentPin,
	input  wire logic        batteryOnly,
	input  wire logic        reverseBoostActive,
	input  wire logic        adapterDetect,
	input  wire logic        throttleCfg,
	input  wire logic        dischargeMonitorCfg,
	input  wire logic        powerMonitorCfg,
	input  wire logic        adcCfg,
	input  wire logic        pfmActive,
	input  wire logic        burstRequest,
	output logic             throttleEnable,
	output logic             dischargeMonitorEnable,
	output logic             powerMonitorEnable,
	output logic             comparatorEnable,
	output logic             adcEnable,
	output logic             adapterGoodOutput,
	output logic             inputCurrentRegulationEnable,
	output logic      [15:0] chargeCurrent,
	output logic      [15:0] chargeVoltage,
	output logic             chargeActive,
	output logic             burstPulse
);

	typedef struct packed {
		logic [7:0]  optLow;
		logic [7:0]  optHigh;
		logic [7:0]  opt1High;
		logic [15:0] current;
		logic [15:0] voltage;
		logic [7:0]  pendData;
		logic [7:0]  pendAddr;
		logic        pendValid;
		logic        suspended;
		logic        wdPrev;
		logic        batMeta;
		logic        batSync;
		logic        batPrev;
		logic [8:0]  burstGap;
		logic [7:0]  rdData;
		logic        throttle;
		logic        dischargeMon;
		logic        powerMon;
		logic        comparator;
		logic        adc;
		logic        adapterGood;
		logic        active;
		logic        burst;
	} ctrl_state_t;

	ctrl_state_t st;
	ctrl_state_t next_st;

	interval_timer_if wdBus ();
	interval_timer_if gapBus ();

	logic lowWrite;
	logic highWrite;
	logic commitOk;
	logic commitCharge;

	// ==========================================================
	// address helpers
	function automatic logic isPairLow(input logic [7:0] a);
		isPairLow = (a == ADDR_OPT0_LOW) || (a == ADDR_CUR_LOW) || (a == ADDR_VOLT_LOW) || (a == ADDR_OPT1_LOW);
	endfunction

	function automatic logic isPairHigh(input logic [7:0] a);
		isPairHigh = (a == ADDR_OPT0_HIGH) || (a == ADDR_CUR_HIGH) || (a == ADDR_VOLT_HIGH)
			|| (a == ADDR_OPT1_HIGH);
	endfunction

	// ==========================================================
	// write pairing and timers
	assign lowWrite     = regWrite && isPairLow(regAddr);
	assign highWrite    = regWrite && isPairHigh(regAddr);
	assign commitOk     = highWrite && st.pendValid && !gapBus.elapsed
		&& (st.pendAddr == (regAddr - 8'h01));
	assign commitCharge = commitOk && (regAddr == ADDR_CUR_HIGH || regAddr == ADDR_VOLT_HIGH
		|| regAddr == ADDR_OPT0_HIGH);

	assign wdBus.sel      = st.optHigh[BIT_WD_SEL_HI:BIT_WD_SEL_LO];
	assign wdBus.restart  = commitCharge;
	assign gapBus.sel     = st.optHigh[BIT_WD_SEL_HI:BIT_WD_SEL_LO];
	assign gapBus.restart = lowWrite;

	interval_timer #(
		.SHORT_CYC (SHORT_CYC),
		.MID_CYC   (MID_CYC),
		.LONG_CYC  (LONG_CYC)
	) watchdogTimer (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tmr   (wdBus.timer)
	);

	interval_timer #(
		.SHORT_CYC (SHORT_CYC),
		.MID_CYC   (MID_CYC),
		.LONG_CYC  (LONG_CYC)
	) pairGapTimer (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tmr   (gapBus.timer)
	);

	// ==========================================================
	// next state
	always_comb
	begin
		logic lowPower;
		logic batFall;
		lowPower = 1'b0;
		batFall  = 1'b0;
		next_st  = st;

		next_st.batMeta = cellCountBatteryPresentPin;
		next_st.batSync = st.batMeta;
		next_st.batPrev = st.batSync;
		next_st.wdPrev  = wdBus.elapsed;

		// pairing of low and high bytes
		if (lowWrite)
		begin
			next_st.pendData  = regWrData;
			next_st.pendAddr  = regAddr;
			next_st.pendValid = 1'b1;
		end
		else if (highWrite || gapBus.elapsed)
			next_st.pendValid = 1'b0;

		// watchdog expiry
		if (wdBus.elapsed && !st.wdPrev)
		begin
			next_st.current   = CUR_SUSPEND;
			next_st.suspended = 1'b1;
		end

		if (commitOk)
		begin
			unique case (regAddr)
				ADDR_OPT0_HIGH:
				begin
					next_st.optLow  = st.pendData;
					next_st.optHigh = regWrData;
				end
				ADDR_CUR_HIGH:  next_st.current  = {regWrData, st.pendData};
				ADDR_VOLT_HIGH: next_st.voltage  = {regWrData, st.pendData};
				ADDR_OPT1_HIGH: next_st.opt1High = regWrData;
				default:        next_st.pendValid = 1'b0;
			endcase
		end
		if (commitCharge)
			next_st.suspended = 1'b0;

		// battery removal drops input regulation, winning over a host write
		batFall = st.batPrev && !st.batSync;
		if (batFall && next_st.optHigh[BIT_INPUT_LIMIT_AUTO])
			next_st.optLow[BIT_INPUT_REG_ENABLE] = 1'b0;

		// read data
		if (regRead)
		begin
			unique case (regAddr)
				ADDR_OPT0_LOW:  next_st.rdData = st.optLow;
				ADDR_OPT0_HIGH: next_st.rdData = st.optHigh;
				ADDR_CUR_LOW:   next_st.rdData = st.current[7:0];
				ADDR_CUR_HIGH:  next_st.rdData = st.current[15:8];
				ADDR_VOLT_LOW:  next_st.rdData = st.voltage[7:0];
				ADDR_VOLT_HIGH: next_st.rdData = st.voltage[15:8];
				ADDR_OPT1_HIGH: next_st.rdData = st.opt1High;
				default:        next_st.rdData = 8'h00;
			endcase
		end

		// low power gating of throttle, monitor and converter enables; comparator not gated
		lowPower = st.optHigh[BIT_LOW_POWER_ENABLE] && batteryOnly;
		next_st.throttle     = lowPower ? 1'b0 : throttleCfg;
		next_st.dischargeMon = lowPower ? 1'b0 : dischargeMonitorCfg;
		next_st.powerMon     = lowPower ? 1'b0 : powerMonitorCfg;
		next_st.adc          = lowPower ? 1'b0 : adcCfg;
		next_st.comparator   = st.opt1High[BIT_CMP_ENABLE_A] || st.opt1High[BIT_CMP_ENABLE_B];

		next_st.adapterGood = adapterDetect
			|| (st.optHigh[BIT_RB_FLAGS_ADAPTER] && reverseBoostActive);

		next_st.active = !st.suspended && (st.current != CUR_SUSPEND)
			&& (st.voltage != VOLT_RESET);

		// burst frequency floor
		next_st.burst = 1'b0;
		if (!pfmActive)
			next_st.burstGap = '0;
		else if (burstRequest || (st.optHigh[BIT_OUT_OF_AUDIO]
			&& st.burstGap >= BURST_GAP_CYC - BURST_GAP_ONE))
		begin
			next_st.burst    = 1'b1;
			next_st.burstGap = '0;
		end
		else
			next_st.burstGap = st.burstGap + BURST_GAP_ONE;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st          <= '0;
			st.optLow   <= OPT0_LOW_RESET;
			st.optHigh  <= OPT0_HIGH_RESET;
			st.opt1High <= OPT1_HIGH_RESET;
			st.current  <= CUR_RESET;
			st.voltage  <= VOLT_RESET;
		end
		else
			st <= next_st;
	end

	// ==========================================================
	// outputs
	assign regRdData                    = st.rdData;
	assign throttleEnable               = st.throttle;
	assign dischargeMonitorEnable       = st.dischargeMon;
	assign powerMonitorEnable           = st.powerMon;
	assign comparatorEnable             = st.comparator;
	assign adcEnable                    = st.adc;
	assign adapterGoodOutput            = st.adapterGood;
	assign inputCurrentRegulationEnable = st.optLow[BIT_INPUT_REG_ENABLE];
	assign chargeCurrent                = st.current;
	assign chargeVoltage                = st.voltage;
	assign chargeActive                 = st.active;
	assign burstPulse                   = st.burst;

endmodule : charger_option_high_byte_ctrl
`default_nettype wire

// >>> charger_opt_monitor.sv
// concurrent checks on the ports of the charger option high-byte block
`timescale 1ns/1ns
`default_nettype none
module charger_opt_monitor
	import charger_opt_pkg::*;
#(
	parameter logic [31:0] LONG_CYC = 32'h0000003C
)(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [7:0]  regAddr,
	input wire logic [7:0]  regWrData,
	input wire logic        regWrite,
	input wire logic        batteryOnly,
	input wire logic        reverseBoostActive,
	input wire logic        adapterDetect,
	input wire logic        throttleCfg,
	input wire logic        powerMonitorCfg,
	input wire logic        adcCfg,
	input wire logic        burstRequest,
	input wire logic        throttleEnable,
	input wire logic        powerMonitorEnable,
	input wire logic        adcEnable,
	input wire logic        adapterGoodOutput,
	input wire logic [15:0] chargeCurrent,
	input wire logic [15:0] chargeVoltage,
	input wire logic        chargeActive,
	input wire logic        burstPulse
);
	logic [31:0] idleCyc;
	logic        chargeWr;
	logic        wdOn;
	assign chargeWr = regWrite && (regAddr == ADDR_CUR_HIGH || regAddr == ADDR_VOLT_HIGH || regAddr == ADDR_OPT0_HIGH);
	// ==========================================================
	// cycles since the last charge command
	always_ff @(posedge mclk)
	begin
		if (!rst_n || chargeWr)
			idleCyc <= 32'h00000000;
		else if (idleCyc != 32'hFFFFFFFF)
			idleCyc <= idleCyc + 32'h00000001;
	end
	// ==========================================================
	// watchdog selection last written by the host
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			wdOn <= 1'b1;
		else if (regWrite && regAddr == ADDR_OPT0_HIGH)
			wdOn <= regWrData[BIT_WD_SEL_HI:BIT_WD_SEL_LO] != WD_OFF;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// assertions
	chk_adapter_detect: assert property (adapterDetect |=> adapterGoodOutput)
		else $error("adapter good not raised");
	chk_adapter_idle: assert property (!adapterDetect && !reverseBoostActive |=> !adapterGoodOutput)
		else $error("adapter good raised without cause");
	chk_perf_follow: assert property (!batteryOnly |=> throttleEnable == $past(throttleCfg)
		&& powerMonitorEnable == $past(powerMonitorCfg))
		else $error("enables do not follow settings");
	chk_adc_gate: assert property (adcEnable |-> $past(adcCfg))
		else $error("converter enabled without setting");
	chk_burst_pass: assert property (burstRequest |=> burstPulse)
		else $error("burst request lost");
	chk_volt_commit: assert property ($changed(chargeVoltage) |-> $past(regWrite)
		&& $past(regAddr) == ADDR_VOLT_HIGH)
		else $error("voltage changed without high write");
	chk_active_valid: assert property (chargeActive |-> $past(chargeCurrent) != 16'h0000
		&& $past(chargeVoltage) != 16'h0000)
		else $error("charging with invalid values");
	chk_watchdog_bound: assert property (wdOn && idleCyc > LONG_CYC + 32'h00000003 |-> chargeCurrent == CUR_SUSPEND)
		else $error("watchdog did not suspend");
endmodule // charger_opt_monitor
bind charger_option_high_byte_ctrl charger_opt_monitor #(.LONG_CYC(LONG_CYC)) mon (.mclk, .rst_n, .regAddr,
	.regWrData, .regWrite, .batteryOnly, .reverseBoostActive, .adapterDetect, .throttleCfg,
	.powerMonitorCfg, .adcCfg, .burstRequest, .throttleEnable, .powerMonitorEnable, .adcEnable,
	.adapterGoodOutput, .chargeCurrent, .chargeVoltage, .chargeActive, .burstPulse);
`default_nettype wire

// >>> reg_host_model.sv
// host model driving the byte-strobe register port
`timescale 1ns/1ns
`default_nettype none
module reg_host_model
	import charger_opt_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic [7:0] regRdData,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWrData,
	output logic            regWrite,
	output logic            regRead
);
	initial
	begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
	end
	// ==========================================================
	// byte access; released data shows the inverse
	task automatic wrByte(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
		regWrData <= ~d;
	endtask
	task automatic wrPair(input logic [7:0] lowAddr, input logic [15:0] v);
		wrByte(lowAddr, v[7:0]);
		wrByte(lowAddr + 8'h01, v[15:8]);
	endtask
	task automatic rdByte(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		@(negedge mclk);
		d = regRdData;
	endtask
endmodule // reg_host_model
`default_nettype wire

// >>> charger_option_high_byte_ctrl_tb.sv
// self-checking testbench for the charger option high-byte block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin fails++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module charger_option_high_byte_ctrl_tb
	import charger_opt_pkg::*;
;
	localparam int N_CYC [1:3] = '{20, 40, 60};
	logic mclk, rst_n, regWrite, regRead, pin, batOnly, rbActive, adDetect, pfm, bReq;
	logic tCfg, dCfg, pCfg, aCfg;
	logic thrE, disE, pwrE, cmpE, adcE, agOut, icrE, chgAct, bPulse;
	logic [7:0] regAddr, regWrData, regRdData, d;
	logic [15:0] chgCur, chgVolt;
	int fails, samplesChecked, cycles, n;
	charger_option_high_byte_ctrl #(.SHORT_CYC(32'h14), .MID_CYC(32'h28), .LONG_CYC(32'h3C)) uut (.mclk, .rst_n,
		.regAddr, .regWrData, .regWrite, .regRead, .regRdData, .cellCountBatteryPresentPin(pin),
		.batteryOnly(batOnly), .reverseBoostActive(rbActive), .adapterDetect(adDetect), .throttleCfg(tCfg),
		.dischargeMonitorCfg(dCfg), .powerMonitorCfg(pCfg), .adcCfg(aCfg), .pfmActive(pfm), .burstRequest(bReq),
		.throttleEnable(thrE), .dischargeMonitorEnable(disE), .powerMonitorEnable(pwrE), .comparatorEnable(cmpE),
		.adcEnable(adcE), .adapterGoodOutput(agOut), .inputCurrentRegulationEnable(icrE),
		.chargeCurrent(chgCur), .chargeVoltage(chgVolt), .chargeActive(chgAct), .burstPulse(bPulse));
	reg_host_model host (.mclk, .regRdData, .regAddr, .regWrData, .regWrite, .regRead);
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// ==========================================================
	// helpers
	task automatic tick(input int k);
		repeat (k) @(negedge mclk);
	endtask
	task automatic setOpt(input logic [7:0] hi);
		host.wrPair(ADDR_OPT0_LOW, {hi, 8'h0E});
		tick(2);
	endtask
	task automatic end_of_test;
		if (fails == 0 && samplesChecked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			end_of_test;
		end
	end
	// ==========================================================
	// scenarios
	task automatic t_lowpower;
		host.rdByte(ADDR_OPT0_HIGH, d);
		`CHK(d, OPT0_HIGH_RESET)
		host.rdByte(8'h40, d);
		`CHK(d, 8'h00)
		@(posedge mclk) {tCfg, dCfg, pCfg, aCfg} <= 4'hA;
		tick(2);
		`CHK({thrE, disE, pwrE, adcE}, 4'hA)
		@(posedge mclk);
		{tCfg, dCfg, pCfg, aCfg} <= 4'hF;
		batOnly <= 1'b1;
		tick(2);
		`CHK({thrE, disE, pwrE, adcE}, 4'h0)
		foreach (N_CYC[i])
		begin
			host.wrPair(ADDR_OPT1_LOW, {8'(8'h80 >> i), 8'h00});
			tick(2);
			`CHK(cmpE, i < 3)
		end
		setOpt(8'h62);
		`CHK({thrE, disE, pwrE, adcE}, 4'hF)
		@(posedge mclk) {tCfg, dCfg, pCfg, aCfg} <= 4'h5;
		tick(2);
		`CHK({thrE, disE, pwrE, adcE}, 4'h5)
	endtask
	task automatic t_watchdog;
		foreach (N_CYC[i])
		begin
			setOpt(8'h02 | 8'(i << 5));
			host.wrPair(ADDR_VOLT_LOW, 16'h1000);
			host.wrPair(ADDR_CUR_LOW, 16'h0200);
			tick(3);
			`CHK(chgAct, 1'b1)
			`CHK(chgVolt, 16'h1000)
			n = 0;
			while (chgCur !== CUR_SUSPEND && n < 300)
			begin
				tick(1);
				n++;
			end
			`CHK((n >= N_CYC[i] - 3) && (n <= N_CYC[i] + 1), 1'b1)
			tick(2);
			`CHK(chgAct, 1'b0)
			host.wrPair(ADDR_VOLT_LOW, 16'h1000);
			tick(3);
			`CHK(chgAct, 1'b0)
			host.wrPair(ADDR_CUR_LOW, 16'h0300);
			tick(3);
			`CHK(chgAct, 1'b1)
		end
		host.wrByte(ADDR_CUR_LOW, 8'h55);
		tick(70);
		host.wrByte(ADDR_CUR_HIGH, 8'h07);
		tick(2);
		`CHK(chgCur, CUR_SUSPEND)
		host.wrPair(ADDR_CUR_LOW, 16'h0400);
		host.wrByte(ADDR_CUR_HIGH, 8'h09);
		tick(2);
		`CHK(chgCur, 16'h0400)
		setOpt(8'h02);
		host.wrPair(ADDR_CUR_LOW, 16'h0500);
		tick(200);
		`CHK(chgCur, 16'h0500)
	endtask
	task automatic t_pins;
		setOpt(8'h12);
		@(posedge mclk) pin <= 1'b0;
		tick(6);
		`CHK(icrE, 1'b0)
		setOpt(8'h12);
		`CHK(icrE, 1'b1)
		@(posedge mclk) pin <= 1'b1;
		setOpt(8'h0A);
		@(posedge mclk) pin <= 1'b0;
		tick(6);
		`CHK({icrE, agOut}, 2'h3)
		setOpt(8'h06);
		`CHK(agOut, 1'b0)
		@(posedge mclk);
		adDetect <= 1'b1;
		rbActive <= 1'b0;
		tick(2);
		`CHK(agOut, 1'b1)
		@(posedge mclk) adDetect <= 1'b0;
		tick(2);
		`CHK(agOut, 1'b0)
		n = 0;
		repeat (450)
		begin
			tick(1);
			n += int'(bPulse === 1'b1);
		end
		`CHK(n > 0, 1'b1)
		setOpt(8'h02);
		n = 0;
		repeat (450)
		begin
			tick(1);
			n += int'(bPulse === 1'b1);
		end
		`CHK(n, 0)
		@(posedge mclk) bReq <= 1'b1;
		@(posedge mclk) bReq <= 1'b0;
		@(negedge mclk);
		`CHK(bPulse, 1'b1)
	endtask
	initial
	begin
		{fails, samplesChecked, cycles} = '0;
		{rst_n, batOnly, adDetect, bReq} = 4'h0;
		{pin, rbActive, pfm} = 3'h7;
		{tCfg, dCfg, pCfg, aCfg} = 4'hF;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		t_lowpower();
		t_watchdog();
		t_pins();
		end_of_test;
	end
endmodule // charger_option_high_byte_ctrl_tb
`default_nettype wire
